// file: hdl/svsw_core.sv
// svsw_core: torque cap, position windows, speed status, pin mapping
// assumes deviation, speed and torque inputs come from logic on mclk_in
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module svsw_core #(
   parameter int N_OUT   = 8,
   parameter int N_EN    = 4,
   parameter int CTL_DIV = svsw_pkg::CTL_CYCLES
) (
   input  wire logic               mclk_in,
   input  wire logic               rst_n_in,
   input  wire logic [7:0]         reg_addr_in,
   input  wire logic [31:0]        reg_wdata_in,
   input  wire logic               reg_wr_in,
   input  wire logic               reg_rd_in,
   output logic      [31:0]        reg_rdata_out,
   input  wire logic [3:0]         seq_ops_in,
   input  wire logic signed [15:0] torque_cmd_in,
   input  wire logic signed [31:0] inc_dev_in,
   input  wire logic signed [31:0] abs_dev_in,
   input  wire logic signed [16:0] speed_in,
   input  wire logic signed [16:0] speed_cmd_in,
   output logic signed [15:0]      torque_out,
   output logic      [N_OUT-1:0]   gp_out,
   output logic      [N_EN-1:0]    func_en_out,
   output logic                    clamp_active_out,
   output logic                    irq_out
);
   if (N_OUT != 8 || N_EN < 1 || N_EN > 4) begin : g_chk
      $error("svsw_core: need N_OUT == 8 and N_EN in 1..4");
   end

   // ***********************************************************
   // control cycle
   // ***********************************************************
   logic tick;

   svsw_tick_div #(.DIV(CTL_DIV)) u_div (
      .mclk_in  (mclk_in),
      .rst_n_in (rst_n_in),
      .tick_out (tick)
   );

   // ***********************************************************
   // register decode
   // ***********************************************************
   wire hit_ctrl  = reg_addr_in == svsw_pkg::A_CTRL;
   wire hit_scap  = reg_addr_in == svsw_pkg::A_SEQ_CAP;
   wire hit_pcap  = reg_addr_in == svsw_pkg::A_PEAK_CAP;
   wire hit_near  = reg_addr_in == svsw_pkg::A_NEAR_WIN;
   wire hit_setl  = reg_addr_in == svsw_pkg::A_SETL_WIN;
   wire hit_low   = reg_addr_in == svsw_pkg::A_LOW_SPD;
   wire hit_high  = reg_addr_in == svsw_pkg::A_HIGH_SPD;
   wire hit_match = reg_addr_in == svsw_pkg::A_MATCH_W;
   wire hit_oslo  = reg_addr_in == svsw_pkg::A_OSEL_LO;
   wire hit_oshi  = reg_addr_in == svsw_pkg::A_OSEL_HI;
   wire hit_esel  = reg_addr_in == svsw_pkg::A_ESEL;
   wire hit_stat  = reg_addr_in == svsw_pkg::A_STATUS;
   wire hit_istat = reg_addr_in == svsw_pkg::A_IRQ_STAT;
   wire hit_imask = reg_addr_in == svsw_pkg::A_IRQ_MASK;

   // out-of-range sequence-cap writes saturate so seq_cap_q never leaves 10..500
   wire [9:0] cap_wv =
      (reg_wdata_in < {22'h0, svsw_pkg::CAP_MIN}) ? svsw_pkg::CAP_MIN :
      (reg_wdata_in > {22'h0, svsw_pkg::CAP_MAX}) ? svsw_pkg::CAP_MAX :
      reg_wdata_in[9:0];
   // a zero window would never match; lowest legal is one pulse
   wire [15:0] win_wv = (reg_wdata_in[15:0] == 16'h0000) ? svsw_pkg::WIN_MIN
                                                        : reg_wdata_in[15:0];
   wire [1:0] mode_wv = (reg_wdata_in[1:0] == 2'h3) ? 2'h1 : reg_wdata_in[1:0];

   svsw_pkg::svsw_mode_t mode_q;
   logic                 enc_abs_q;
   logic [9:0]           seq_cap_q;
   logic [9:0]           peak_q;
   logic [15:0]          near_w_q;
   logic [15:0]          settle_w_q;
   logic [15:0]          low_q;
   logic [15:0]          high_q;
   logic [15:0]          match_q;
   logic [63:0]          out_sel_q;
   logic [31:0]          en_sel_q;
   logic [svsw_pkg::IRQ_W-1:0] irq_stat_q;
   logic [svsw_pkg::IRQ_W-1:0] irq_mask_q;
   logic [svsw_pkg::IRQ_W-1:0] irq_ev;
   logic [31:0]          rdata_q;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         mode_q     <= svsw_pkg::MODE_POS;
         enc_abs_q  <= 1'b0;
         seq_cap_q  <= svsw_pkg::RST_SEQ_CAP;
         peak_q     <= svsw_pkg::RST_PEAK_CAP;
         near_w_q   <= svsw_pkg::RST_NEAR_WIN;
         settle_w_q <= svsw_pkg::RST_SETL_WIN;
         low_q      <= svsw_pkg::RST_LOW_SPD;
         high_q     <= svsw_pkg::RST_HIGH_SPD;
         match_q    <= svsw_pkg::RST_MATCH_W;
         out_sel_q  <= '0;
         en_sel_q   <= '0;
         irq_mask_q <= '0;
      end else if (reg_wr_in) begin
         if (hit_ctrl) begin
            mode_q    <= svsw_pkg::svsw_mode_t'(mode_wv);
            enc_abs_q <= reg_wdata_in[svsw_pkg::CTRL_ENC_ABS];
         end
         if (hit_scap)  seq_cap_q  <= cap_wv;
         if (hit_pcap)  peak_q     <= reg_wdata_in[9:0];
         if (hit_near)  near_w_q   <= win_wv;
         if (hit_setl)  settle_w_q <= win_wv;
         if (hit_low)   low_q      <= reg_wdata_in[15:0];
         if (hit_high)  high_q     <= reg_wdata_in[15:0];
         if (hit_match) match_q    <= reg_wdata_in[15:0];
         if (hit_oslo)  out_sel_q[31:0]  <= reg_wdata_in;
         if (hit_oshi)  out_sel_q[63:32] <= reg_wdata_in;
         if (hit_esel)  en_sel_q   <= reg_wdata_in;
         if (hit_imask) irq_mask_q <= reg_wdata_in[svsw_pkg::IRQ_W-1:0];
      end
   end

   // ***********************************************************
   // sequence torque cap
   // ***********************************************************
   wire               seq_any = |seq_ops_in;
   wire [9:0]         eff_cap = (seq_cap_q > peak_q) ? peak_q : seq_cap_q;
   wire signed [15:0] lim_pos = signed'({6'h00, eff_cap});
   wire signed [15:0] lim_neg = -lim_pos;
   wire signed [15:0] trq_d   =
      !seq_any               ? torque_cmd_in :
      (torque_cmd_in > lim_pos) ? lim_pos :
      (torque_cmd_in < lim_neg) ? lim_neg : torque_cmd_in;

   // ***********************************************************
   // status comparisons
   // ***********************************************************
   wire               pos_mode = mode_q == svsw_pkg::MODE_POS;
   wire               trq_mode = mode_q == svsw_pkg::MODE_TRQ;
   // deviation arrives in encoder pulses, gearing already removed
   wire signed [31:0] dev_sel  = enc_abs_q ? abs_dev_in : inc_dev_in;
   wire [31:0]        dev_mag  = dev_sel[31] ? 32'(-dev_sel) : 32'(dev_sel);
   wire [16:0]        spd_mag  = speed_in[16] ? 17'(-speed_in) : 17'(speed_in);
   wire signed [17:0] sdiff    = 18'(speed_cmd_in) - 18'(speed_in);
   wire [17:0]        sdev_mag = sdiff[17] ? 18'(-sdiff) : 18'(sdiff);

   svsw_pkg::svsw_stat_t stat_d;
   svsw_pkg::svsw_stat_t stat_q;

   // with near wider than settle, near is true whenever settle is
   assign stat_d.near   = pos_mode && dev_mag < {16'h0, near_w_q};
   assign stat_d.settle = pos_mode && dev_mag < {16'h0, settle_w_q};
   assign stat_d.slow   = spd_mag < {1'b0, low_q};
   assign stat_d.fast   = spd_mag > {1'b0, high_q};
   assign stat_d.match  = !trq_mode && sdev_mag < {2'h0, match_q};

   // ***********************************************************
   // pin and enable selection
   // ***********************************************************
   function automatic logic pin_val(input logic [7:0] c,
                                    input svsw_pkg::svsw_stat_t s);
      logic r;
      r = 1'b0;
      unique case (c)
         svsw_pkg::SLOW_ON:     r = s.slow;
         svsw_pkg::SLOW_OFF:    r = !s.slow;
         svsw_pkg::FAST_ON:     r = s.fast;
         svsw_pkg::FAST_OFF:    r = !s.fast;
         svsw_pkg::MATCH_ON:    r = s.match;
         svsw_pkg::MATCH_OFF:   r = !s.match;
         svsw_pkg::SETTLED_ON:  r = s.settle;
         svsw_pkg::SETTLED_OFF: r = !s.settle;
         svsw_pkg::NEAR_ON:     r = s.near;
         svsw_pkg::NEAR_OFF:    r = !s.near;
         default:               r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic en_val(input logic [7:0] c,
                                   input svsw_pkg::svsw_stat_t s);
      logic r;
      r = 1'b0;
      unique case (c)
         svsw_pkg::EN_SLOW:      r = s.slow;
         svsw_pkg::EN_NOT_SLOW:  r = !s.slow;
         svsw_pkg::EN_FAST:      r = s.fast;
         svsw_pkg::EN_NOT_FAST:  r = !s.fast;
         svsw_pkg::EN_MATCH:     r = s.match;
         svsw_pkg::EN_NOT_MATCH: r = !s.match;
         default:                r = 1'b0;
      endcase
      return r;
   endfunction

   logic [N_OUT-1:0] gp_d;
   logic [N_EN-1:0]  en_d;
   logic [N_OUT-1:0] gp_q;
   logic [N_EN-1:0]  en_q;

   for (genvar i = 0; i < N_OUT; i++) begin : g_pin
      assign gp_d[i] = pin_val(out_sel_q[8*i +: 8], stat_d);
   end
   for (genvar j = 0; j < N_EN; j++) begin : g_en
      assign en_d[j] = en_val(en_sel_q[8*j +: 8], stat_d);
   end

   // ***********************************************************
   // control-cycle update
   // ***********************************************************
   // everything moves on one tick so the host never sees a mixed set
   logic signed [15:0] trq_q;
   logic               clamp_q;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         stat_q  <= '0;
         gp_q    <= '0;
         en_q    <= '0;
         trq_q   <= '0;
         clamp_q <= 1'b0;
      end else if (tick) begin
         stat_q  <= stat_d;
         gp_q    <= gp_d;
         en_q    <= en_d;
         trq_q   <= trq_d;
         clamp_q <= seq_any;
      end
   end

   // ***********************************************************
   // interrupts and read-back
   // ***********************************************************
   // rising edges of each status and of the clamp, seen at a tick
   // a status already high when reset ends fires once at the first tick
   assign irq_ev = tick ? ({seq_any, stat_d} & ~{clamp_q, stat_q}) : '0;
   wire [svsw_pkg::IRQ_W-1:0] w1c = (reg_wr_in && hit_istat)
                                    ? reg_wdata_in[svsw_pkg::IRQ_W-1:0] : '0;

   // unmapped offsets read zero so software can probe the map safely
   logic [31:0] rd_mux;
   assign rd_mux =
      hit_ctrl  ? {29'h0, enc_abs_q, mode_q} :
      hit_scap  ? {22'h0, seq_cap_q} :
      hit_pcap  ? {22'h0, peak_q} :
      hit_near  ? {16'h0, near_w_q} :
      hit_setl  ? {16'h0, settle_w_q} :
      hit_low   ? {16'h0, low_q} :
      hit_high  ? {16'h0, high_q} :
      hit_match ? {16'h0, match_q} :
      hit_oslo  ? out_sel_q[31:0] :
      hit_oshi  ? out_sel_q[63:32] :
      hit_esel  ? en_sel_q :
      hit_stat  ? 32'({en_q, gp_q, 2'h0, clamp_q, stat_q}) :
      hit_istat ? {26'h0, irq_stat_q} :
      hit_imask ? {26'h0, irq_mask_q} : 32'h0;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         irq_stat_q <= '0;
         rdata_q    <= '0;
      end else begin
         // a new event beats a clear in the same cycle
         irq_stat_q <= (irq_stat_q & ~w1c) | irq_ev;
         rdata_q    <= reg_rd_in ? rd_mux : 32'h0;
      end
   end

   assign reg_rdata_out    = rdata_q;
   assign torque_out       = trq_q;
   assign gp_out           = gp_q;
   assign func_en_out      = en_q;
   assign clamp_active_out = clamp_q;
   assign irq_out          = |(irq_stat_q & irq_mask_q);

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   // most checks are gated by tick; between ticks stat_q and gp_q may not move
   wire [15:0] trq_mag = trq_q[15] ? 16'(-trq_q) : 16'(trq_q);

   sequence s_pos_tick;
      tick && mode_q == svsw_pkg::MODE_POS;
   endsequence
   sequence s_in_settle;
      dev_mag < {16'h0, settle_w_q} && near_w_q > settle_w_q;
   endsequence

   AST_CAP_RANGE: assert property (
      seq_cap_q >= svsw_pkg::CAP_MIN && seq_cap_q <= svsw_pkg::CAP_MAX)
      else $error("sequence cap out of range");
   AST_CLAMP: assert property (
      tick && seq_any |=> trq_mag <= {6'h00, $past(eff_cap)})
      else $error("torque exceeds cap during sequence");
   AST_PEAK: assert property (
      seq_cap_q > peak_q |-> eff_cap == peak_q)
      else $error("peak torque not used as cap");
   AST_NOT_POS: assert property (
      tick && !pos_mode |=> !stat_q.near && !stat_q.settle)
      else $error("window status outside position mode");
   AST_NEAR: assert property (
      s_pos_tick ##0 dev_mag < {16'h0, near_w_q} |=> stat_q.near)
      else $error("near status missing");
   AST_SETTLE: assert property (
      s_pos_tick ##0 dev_mag >= {16'h0, settle_w_q} |=> !stat_q.settle)
      else $error("settled without small deviation");
   AST_NEAR_FIRST: assert property (
      s_pos_tick ##0 s_in_settle |=> stat_q.near && stat_q.settle)
      else $error("settled reported without near");
   AST_SLOW_PIN: assert property (
      tick && out_sel_q[7:0] == svsw_pkg::SLOW_OFF |=> gp_q[0] == !stat_q.slow)
      else $error("pin 0 slow-off mapping wrong");
   AST_FAST: assert property (
      tick && spd_mag > {1'b0, high_q} |=> stat_q.fast ##1 (tick || stat_q.fast))
      else $error("fast status missing");
   AST_MATCH_TQ: assert property (
      tick && trq_mode |=> !stat_q.match)
      else $error("match status in torque mode");
   AST_EN_FAST: assert property (
      tick && en_sel_q[7:0] == svsw_pkg::EN_NOT_FAST |=> en_q[0] == !stat_q.fast)
      else $error("enable 0 not-fast mapping wrong");
   AST_HOLD: assert property (
      !tick |=> $stable(stat_q) && $stable(gp_q))
      else $error("status changed between control cycles");
endmodule // svsw_core

// file: hdl/svsw_pkg.sv
// svsw_pkg: register map, reset values, selection codes and types
// assumes one 125 MHz clock; all users write svsw_pkg::name
package svsw_pkg;
   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int CTL_PERIOD_NS = 1000;
   localparam int CTL_CYCLES    = CTL_PERIOD_NS / CLK_PERIOD_NS;

   // ***********************************************************
   // register byte offsets
   // ***********************************************************
   localparam logic [7:0] A_CTRL     = 8'h00;
   localparam logic [7:0] A_SEQ_CAP  = 8'h04;
   localparam logic [7:0] A_PEAK_CAP = 8'h08;
   localparam logic [7:0] A_NEAR_WIN = 8'h0c;
   localparam logic [7:0] A_SETL_WIN = 8'h10;
   localparam logic [7:0] A_LOW_SPD  = 8'h14;
   localparam logic [7:0] A_HIGH_SPD = 8'h18;
   localparam logic [7:0] A_MATCH_W  = 8'h1c;
   localparam logic [7:0] A_OSEL_LO  = 8'h20;
   localparam logic [7:0] A_OSEL_HI  = 8'h24;
   localparam logic [7:0] A_ESEL     = 8'h28;
   localparam logic [7:0] A_STATUS   = 8'h2c;
   localparam logic [7:0] A_IRQ_STAT = 8'h30;
   localparam logic [7:0] A_IRQ_MASK = 8'h34;

   // ***********************************************************
   // field positions and limits
   // ***********************************************************
   localparam int CTRL_ENC_ABS = 2;
   localparam int ST_CLAMP     = 5;
   localparam int ST_GP_LSB    = 8;
   localparam int ST_EN_LSB    = 16;
   localparam int IRQ_W        = 6;
   localparam logic [9:0] CAP_MIN = 10'h00a;
   localparam logic [9:0] CAP_MAX = 10'h1f4;
   localparam logic [15:0] WIN_MIN = 16'h0001;

   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [9:0]  RST_SEQ_CAP  = 10'h1f4;
   localparam logic [9:0]  RST_PEAK_CAP = 10'h12c;
   localparam logic [15:0] RST_NEAR_WIN = 16'h0064;
   localparam logic [15:0] RST_SETL_WIN = 16'h000a;
   localparam logic [15:0] RST_LOW_SPD  = 16'h0032;
   localparam logic [15:0] RST_HIGH_SPD = 16'h03e8;
   localparam logic [15:0] RST_MATCH_W  = 16'h0032;

   // ***********************************************************
   // output and enable selection codes
   // ***********************************************************
   localparam logic [7:0] SLOW_ON     = 8'h10;
   localparam logic [7:0] SLOW_OFF    = 8'h11;
   localparam logic [7:0] FAST_ON     = 8'h12;
   localparam logic [7:0] FAST_OFF    = 8'h13;
   localparam logic [7:0] MATCH_ON    = 8'h14;
   localparam logic [7:0] MATCH_OFF   = 8'h15;
   localparam logic [7:0] SETTLED_ON  = 8'h18;
   localparam logic [7:0] SETTLED_OFF = 8'h19;
   localparam logic [7:0] NEAR_ON     = 8'h1a;
   localparam logic [7:0] NEAR_OFF    = 8'h1b;
   localparam logic [7:0] EN_SLOW      = 8'h12;
   localparam logic [7:0] EN_NOT_SLOW  = 8'h13;
   localparam logic [7:0] EN_FAST      = 8'h14;
   localparam logic [7:0] EN_NOT_FAST  = 8'h15;
   localparam logic [7:0] EN_MATCH     = 8'h16;
   localparam logic [7:0] EN_NOT_MATCH = 8'h17;

   typedef enum logic [1:0] {MODE_POS, MODE_VEL, MODE_TRQ} svsw_mode_t;

   typedef struct packed {
      logic match;
      logic fast;
      logic slow;
      logic settle;
      logic near;
   } svsw_stat_t;
endpackage

// file: hdl/svsw_tick_div.sv
// svsw_tick_div: one-cycle control-cycle enable from a free counter
// assumes synchronous active-low reset on the same clock
`timescale 1ns/1ps
module svsw_tick_div #(
   parameter int DIV = svsw_pkg::CTL_CYCLES
) (
   input  wire logic mclk_in,
   input  wire logic rst_n_in,
   output logic      tick_out
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_q;
   logic          tick_q;
   wire           wrap = (cnt_q == LAST);

   if (DIV < 2) begin : g_chk
      $error("svsw_tick_div: DIV must be at least 2");
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
         tick_q <= wrap;
      end
   end

   assign tick_out = tick_q;
endmodule // svsw_tick_div

// file: testbench/svsw_host_model.sv
// svsw_host_model: host side, feeds motion feedback and reads the pins
// assumes targets come from the bench on the core's clock
`timescale 1ns/1ps
module svsw_host_model (
   input  wire logic               mclk_in,
   input  wire logic               abs_sel_in,
   input  wire logic signed [31:0] dev_in,
   input  wire logic signed [16:0] spd_in,
   input  wire logic signed [16:0] cmd_in,
   input  wire logic [7:0]         gp_in,
   output logic signed [31:0]      inc_dev_out,
   output logic signed [31:0]      abs_dev_out,
   output logic signed [16:0]      speed_out,
   output logic signed [16:0]      speed_cmd_out,
   output logic [7:0]              gp_seen_out
);
   // ************************************************
   // feedback, changed just after the edge
   // ************************************************
   always @(posedge mclk_in) begin
      // the unused encoder carries a far value, so a wrong pick shows
      inc_dev_out   <= abs_sel_in ? (dev_in ^ 32'sh4000_0000) : dev_in;
      abs_dev_out   <= abs_sel_in ? dev_in : (dev_in ^ 32'sh4000_0000);
      speed_out     <= spd_in;
      speed_cmd_out <= cmd_in;
      gp_seen_out   <= gp_in;
   end
endmodule // svsw_host_model

// file: testbench/svsw_core_bench.sv
// svsw_core_bench: register-level tests of the status compare core
// assumes svsw_pkg, svsw_core and svsw_host_model compiled first
`timescale 1ns/1ps
module svsw_core_bench;
   localparam int DIV = 4;
   logic               mclk_in = 1'b0;
   logic               rst_n_in = 1'b0;
   logic [7:0]         addr = 8'h00;
   logic [31:0]        wdata = 32'h0;
   logic [31:0]        rdata;
   logic [31:0]        rd_word;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   logic               abs_sel = 1'b0;
   logic [3:0]         seq_ops = 4'h0;
   logic signed [15:0] trq_cmd = 16'sh0;
   logic signed [15:0] trq;
   logic signed [31:0] dev = 32'sh0;
   logic signed [31:0] inc_dev, abs_dev;
   logic signed [16:0] spd = 17'sh0;
   logic signed [16:0] cmd = 17'sh0;
   logic signed [16:0] speed, speed_cmd;
   logic [7:0]         gp, gp_seen;
   logic [3:0]         en;
   logic               clamp, irq;
   logic [7:0]         pin_code [8];
   logic [7:0]         en_code [4];
   int                 miscompares = 0;
   int                 checks = 0;
   int                 cyc = 0;
   logic [39:0]        rst_tab [8] = '{{svsw_pkg::A_SEQ_CAP, 32'h1f4},
      {svsw_pkg::A_PEAK_CAP, 32'h12c}, {svsw_pkg::A_NEAR_WIN, 32'h64},
      {svsw_pkg::A_SETL_WIN, 32'h0a}, {svsw_pkg::A_LOW_SPD, 32'h32},
      {svsw_pkg::A_HIGH_SPD, 32'h3e8}, {svsw_pkg::A_MATCH_W, 32'h32}, {8'h3c, 32'h0}};

   always #4 mclk_in = ~mclk_in;

   svsw_core #(.CTL_DIV(DIV)) DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .seq_ops_in(seq_ops), .torque_cmd_in(trq_cmd),
      .inc_dev_in(inc_dev), .abs_dev_in(abs_dev), .speed_in(speed),
      .speed_cmd_in(speed_cmd), .torque_out(trq), .gp_out(gp), .func_en_out(en),
      .clamp_active_out(clamp), .irq_out(irq));

   svsw_host_model host (.mclk_in(mclk_in), .abs_sel_in(abs_sel), .dev_in(dev),
      .spd_in(spd), .cmd_in(cmd), .gp_in(gp), .inc_dev_out(inc_dev),
      .abs_dev_out(abs_dev), .speed_out(speed), .speed_cmd_out(speed_cmd),
      .gp_seen_out(gp_seen));

   // ************************************************
   // access tasks and expectations
   // ************************************************
   task automatic give_verdict();
      if (miscompares == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a);
      @(posedge mclk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      @(negedge mclk_in);
      rd_word = rdata;
   endtask

   function automatic logic [4:0] stat_of(input int md, input int dv, input int sp,
                                          input int cm);
      int ad, as, ae;
      ad = dv < 0 ? -dv : dv;
      as = sp < 0 ? -sp : sp;
      ae = cm > sp ? cm - sp : sp - cm;
      return {md != 2 && ae < 50, as > 1000, as < 50, md == 0 && ad < 10, md == 0 && ad < 100};
   endfunction

   function automatic logic pin_of(input logic [7:0] c, input logic [4:0] s);
      case (c)
         8'h10: return s[2];
         8'h11: return !s[2];
         8'h12: return s[3];
         8'h13: return !s[3];
         8'h14: return s[4];
         8'h15: return !s[4];
         8'h18: return s[1];
         8'h19: return !s[1];
         8'h1a: return s[0];
         8'h1b: return !s[0];
         default: return 1'b0;
      endcase
   endfunction

   task automatic set_sel(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] es);
      wr_reg(svsw_pkg::A_OSEL_LO, lo);
      wr_reg(svsw_pkg::A_OSEL_HI, hi);
      wr_reg(svsw_pkg::A_ESEL, es);
      for (int i = 0; i < 4; i++) begin
         pin_code[i] = lo[8*i +: 8];
         pin_code[i+4] = hi[8*i +: 8];
         en_code[i] = es[8*i +: 8];
      end
   endtask

   // two full control ticks after the host feedback has moved
   task automatic step(input int md, input int dv, input int sp, input int cm);
      logic [4:0] s;
      logic [7:0] eg;
      logic [3:0] ee;
      wr_reg(svsw_pkg::A_CTRL, {29'h0, abs_sel, 2'(md)});
      @(posedge mclk_in);
      dev <= 32'(dv);
      spd <= 17'(sp);
      cmd <= 17'(cm);
      repeat (2*DIV+2) @(posedge mclk_in);
      @(negedge mclk_in);
      s = stat_of(md, dv, sp, cm);
      for (int i = 0; i < 8; i++) eg[i] = pin_of(pin_code[i], s);
      for (int i = 0; i < 4; i++) begin
         ee[i] = (en_code[i] >= 8'h12 && en_code[i] <= 8'h17) ? pin_of(en_code[i] - 8'h02, s) : 1'b0;
      end
      chk({24'h0, gp_seen}, {24'h0, eg});
      chk({28'h0, en}, {28'h0, ee});
      rd_reg(svsw_pkg::A_STATUS);
      chk({27'h0, rd_word[4:0]}, {27'h0, s});
   endtask

   task automatic tq(input logic [3:0] so, input int tc, input int ex);
      @(posedge mclk_in);
      seq_ops <= so;
      trq_cmd <= 16'(tc);
      repeat (2*DIV+2) @(posedge mclk_in);
      @(negedge mclk_in);
      chk({16'h0, trq}, {16'h0, 16'(ex)});
      chk({31'h0, clamp}, {31'h0, so != 4'h0});
   endtask

   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end

   // ************************************************
   // test sequence
   // ************************************************
   initial begin
      repeat (6) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      foreach (rst_tab[i]) begin
         rd_reg(rst_tab[i][39:32]);
         chk(rd_word, rst_tab[i][31:0]);
      end
      tq(4'h1, 400, 300);
      wr_reg(svsw_pkg::A_SEQ_CAP, 32'h64);
      tq(4'h2, 400, 100);
      tq(4'h8, -400, -100);
      tq(4'h4, 90, 90);
      tq(4'h0, 400, 400);
      wr_reg(svsw_pkg::A_SEQ_CAP, 32'h5);
      rd_reg(svsw_pkg::A_SEQ_CAP);
      chk(rd_word, 32'h0a);
      wr_reg(svsw_pkg::A_SEQ_CAP, 32'h3e8);
      rd_reg(svsw_pkg::A_SEQ_CAP);
      chk(rd_word, 32'h1f4);
      wr_reg(svsw_pkg::A_PEAK_CAP, 32'h3c);
      tq(4'h1, -200, -60);
      wr_reg(svsw_pkg::A_HIGH_SPD, 32'hffff);
      rd_reg(svsw_pkg::A_HIGH_SPD);
      chk(rd_word, 32'hffff);
      wr_reg(svsw_pkg::A_HIGH_SPD, 32'h3e8);
      set_sel(32'h13121011, 32'h1b1a1514, 32'h12141315);
      step(0, 200, 49, 49);
      step(0, 100, 50, 120);
      step(0, 99, 1000, 1000);
      step(0, -9, 1001, 1049);
      step(2, 5, -1001, -1001);
      step(1, 5, 0, 60);
      set_sel(32'h19181b1a, 32'h13121110, 32'h17161312);
      step(0, 10, 49, 0);
      step(0, 9, 65535, 0);
      abs_sel = 1'b1;
      step(0, 3, 0, 0);
      abs_sel = 1'b0;
      step(0, -50, 500, 500);
      wr_reg(svsw_pkg::A_IRQ_STAT, 32'h3f);
      wr_reg(svsw_pkg::A_IRQ_MASK, 32'h01);
      step(0, 500, 500, 500);
      wr_reg(svsw_pkg::A_IRQ_STAT, 32'h3f);
      @(negedge mclk_in);
      chk({31'h0, irq}, 32'h0);
      step(0, 50, 500, 500);
      chk({31'h0, irq}, 32'h1);
      wr_reg(svsw_pkg::A_IRQ_STAT, 32'h01);
      step(0, 5, 500, 500);
      chk({31'h0, irq}, 32'h0);
      rd_reg(svsw_pkg::A_IRQ_STAT);
      chk({30'h0, rd_word[1:0]}, 32'h2);
      give_verdict();
   end
endmodule // svsw_core_bench
